// ---- sdil_bench.sv ----
// Self-checking testbench for the serial converter input logic
module sdil_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, clear_strobe_n = 1;
    wire logic serial_clk, unit_select_n, serial_code_in, load_strobe_n;
    wire logic [11:0] analog_output, shift_contents;
    wire logic [20:0] analog_output_uv;
    wire logic [3:0] bit_count;
    wire logic overrun, at_zero, dac_transparent, code_complete, at_full_scale, at_mid_scale;
    integer num_errors = 0, comparisons = 0, seed = 32'h71c0, sh = 0, dac = 0, k;
    always #12.5 clk = ~clk;
    sdil_host host (.clk(clk), .serial_clk(serial_clk), .unit_select_n(unit_select_n),
        .serial_code_in(serial_code_in), .load_strobe_n(load_strobe_n));
    sdil_top DUT (.clk(clk), .rst(rst), .serial_clk(serial_clk), .unit_select_n(unit_select_n),
        .serial_code_in(serial_code_in), .load_strobe_n(load_strobe_n),
        .clear_strobe_n(clear_strobe_n), .analog_output(analog_output),
        .analog_output_uv(analog_output_uv), .shift_contents(shift_contents),
        .bit_count(bit_count), .code_complete(code_complete), .overrun(overrun),
        .dac_transparent(dac_transparent), .at_full_scale(at_full_scale),
        .at_mid_scale(at_mid_scale), .at_zero(at_zero));
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task test_done;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ==========================================
    // Send a frame, then load when w is positive
    task step(input logic [15:0] c, input integer n, input logic sel_n, input integer w);
        host.send(c, n, sel_n);
        if (!sel_n) sh = ((sh << n) | c) & 32'hfff;
        chk(shift_contents, sh);
        chk(analog_output, dac);
        if (!sel_n) begin
            chk(overrun, n > 12);
            chk(bit_count, n > 12 ? 12 : n);
            chk(code_complete, n >= 12);
        end
        if (w > 0) begin
            host.load(w);
            dac = sh;
            chk(dac_transparent, 1);
            chk(bit_count, 0);
            chk(analog_output, dac);
            chk(analog_output_uv, dac * 500);
            chk(at_full_scale, dac == 12'hfff);
            chk(at_mid_scale, dac == 12'h800);
            chk(at_zero, dac == 0);
        end
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rst = 0;
        chk(at_zero, 1);
        for (k = 0; k < 8; k++)
            step(k == 0 ? 12'hfff : k == 1 ? 12'h800 : k == 2 ? 12'h000 : $random(seed),
                12, 0, 1 + k % 3);
        step($random(seed), 12, 1, 0);
        step($random(seed) & 32'h7fff, 15, 0, 2);
        @(negedge clk) clear_strobe_n = 0;
        host.load(2);
        @(negedge clk) clear_strobe_n = 1;
        dac = 0;
        chk(analog_output, dac);
        chk(at_zero, 1);
        chk(dac_transparent, 0);
        host.load(1);
        dac = sh;
        chk(analog_output, dac);
        test_done;
    end
    initial begin
        #100000;
        num_errors++;
        test_done;
    end
endmodule // sdil_bench
bind sdil_top sdil_chk chk_i (.clk(clk), .rst(rst), .serial_clk(serial_clk),
    .unit_select_n(unit_select_n), .serial_code_in(serial_code_in),
    .load_strobe_n(load_strobe_n), .clear_strobe_n(clear_strobe_n),
    .analog_output(analog_output), .analog_output_uv(analog_output_uv),
    .shift_contents(shift_contents), .dac_transparent(dac_transparent));

// ---- sdil_chk.sv ----
// Assertion checker for the serial converter input logic
`include "sdil_defines.vh"
module sdil_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Host side
    input wire logic serial_clk,
    input wire logic unit_select_n,
    input wire logic serial_code_in,
    input wire logic load_strobe_n,
    input wire logic clear_strobe_n,
    // Registers
    input wire logic [`SDIL_CODE_W-1:0] analog_output,
    input wire logic [`SDIL_UV_W-1:0] analog_output_uv,
    input wire logic [`SDIL_CODE_W-1:0] shift_contents,
    input wire logic dac_transparent
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_load_copy: assert property (
        !load_strobe_n && clear_strobe_n |=> analog_output == $past(shift_contents))
        else $error("load did not copy shift register");
    a_load_level: assert property (
        !load_strobe_n && clear_strobe_n |=> dac_transparent) else $error("load not transparent");
    a_clear_zero: assert property (
        !clear_strobe_n |=> analog_output == 12'h000 && !dac_transparent)
        else $error("clear did not zero dac");
    a_dac_hold: assert property (
        load_strobe_n && clear_strobe_n |=> $stable(analog_output)) else $error("dac moved");
    a_shift_order: assert property (
        serial_clk && !$past(serial_clk) && !unit_select_n
        |=> shift_contents == {$past(shift_contents[10:0]), $past(serial_code_in)})
        else $error("bad shift");
    a_select_idle: assert property (
        unit_select_n |=> $stable(shift_contents)) else $error("shift while deselected");
    a_uv_step: assert property (
        analog_output_uv == analog_output * 21'h1f4) else $error("bad output level");
    a_transp_follow: assert property (
        dac_transparent |-> analog_output == shift_contents) else $error("transparent mismatch");
    c_load: cover property (!load_strobe_n && unit_select_n);
    c_clear: cover property (!clear_strobe_n && !load_strobe_n);
    c_shift: cover property (serial_clk && !unit_select_n);
endmodule // sdil_chk

// ---- sdil_defines.vh ----
// Constants for the serial converter input logic
`ifndef SDIL_DEFINES_VH
`define SDIL_DEFINES_VH

// ==========================================
// Widths
`define SDIL_CODE_W 12
`define SDIL_CNT_W 4
`define SDIL_UV_W 21

// ==========================================
// Reset values and counts
`define SDIL_CODE_RST 12'h000
`define SDIL_CNT_RST 4'h0
`define SDIL_CNT_FULL 4'hc
`define SDIL_UV_RST 21'h00000

// ==========================================
// Code points and output step
`define SDIL_CODE_FULL_SCALE 12'hfff
`define SDIL_CODE_MID_SCALE 12'h800
`define SDIL_CODE_ZERO 12'h000
`define SDIL_STEP_UV 21'h001f4

`endif

// ---- sdil_edge.v ----
// Edge detector for a pin sampled on the system clock
module sdil_edge #(
    parameter RESET_LEVEL = 1'b1
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Sampled pin
    input wire level_in,
    // Edge pulses
    output wire rise,
    output wire fall
);
    reg prev_reg;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_reg <= RESET_LEVEL;
        end else begin
            prev_reg <= level_in;
        end
    end

    assign rise = level_in & ~prev_reg;
    assign fall = ~level_in & prev_reg;
endmodule // sdil_edge

// ---- sdil_host.sv ----
// Host model driving the three-wire serial link
module sdil_host (
    // Clock
    input wire logic clk,
    // Serial link and load
    output logic serial_clk,
    output logic unit_select_n,
    output logic serial_code_in,
    output logic load_strobe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {serial_clk, unit_select_n, serial_code_in, load_strobe_n} = 4'h5;
    task send(input logic [15:0] c, input integer n, input logic sel_n);
        integer i;
        @(negedge clk) unit_select_n = sel_n;
        for (i = n - 1; i >= 0; i--) begin
            @(negedge clk) serial_code_in = c[i];
            serial_clk = 1;
            @(negedge clk) serial_clk = 0;
        end
        // Stale data never lingers once the frame ends
        @(negedge clk) serial_code_in = ~serial_code_in;
        unit_select_n = 1;
    endtask
    task load(input integer w);
        @(negedge clk) load_strobe_n = 0;
        repeat (w) @(negedge clk);
        load_strobe_n = 1;
    endtask
endmodule // sdil_host

// ---- sdil_top.v ----
// Serial input shift register and double-buffered DAC register
`include "sdil_defines.vh"

module sdil_top (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Serial link from host
    input wire serial_clk,
    input wire unit_select_n,
    input wire serial_code_in,
    // Transfer and clear strobes
    input wire load_strobe_n,
    input wire clear_strobe_n,
    // DAC register and level
    output reg [`SDIL_CODE_W-1:0] analog_output,
    output reg [`SDIL_UV_W-1:0] analog_output_uv,
    // Shift status and DAC flags
    output reg [`SDIL_CODE_W-1:0] shift_contents,
    output reg [`SDIL_CNT_W-1:0] bit_count,
    output reg code_complete,
    output reg overrun,
    output reg dac_transparent,
    output reg at_full_scale,
    output reg at_mid_scale,
    output reg at_zero
);

    // ==========================================
    // Edge detection
    wire sclk_rise;
    wire load_fall;
    wire sel_fall;

    // Serial clock idles low between frames
    sdil_edge #(.RESET_LEVEL(1'b0)) u_sclk_edge (
        .clk(clk),
        .rst(rst),
        .level_in(serial_clk),
        .rise(sclk_rise),
        .fall()
    );

    // Load fall closes a frame and restarts the count
    sdil_edge #(.RESET_LEVEL(1'b1)) u_load_edge (
        .clk(clk),
        .rst(rst),
        .level_in(load_strobe_n),
        .rise(),
        .fall(load_fall)
    );

    // Select fall marks the start of a new frame
    sdil_edge #(.RESET_LEVEL(1'b1)) u_sel_edge (
        .clk(clk),
        .rst(rst),
        .level_in(unit_select_n),
        .rise(),
        .fall(sel_fall)
    );

    // ==========================================
    // Shift register, separate from the DAC register
    reg [`SDIL_CODE_W-1:0] shift_reg;
    reg [`SDIL_CODE_W-1:0] shift_next;
    reg [`SDIL_CNT_W-1:0] cnt_reg;
    reg [`SDIL_CNT_W-1:0] cnt_next;
    reg ovr_reg;
    reg ovr_next;
    wire shift_en;
    wire frame_restart;

    // Select gates the clock only; load is never gated by it
    assign shift_en = sclk_rise & ~unit_select_n;

    // A load closes the old frame, a select fall opens a new one
    assign frame_restart = load_fall | sel_fall;

    // Shift data path
    always @* begin
        shift_next = shift_reg;
        if (shift_en) begin
            // Oldest bit falls off the top
            shift_next = {shift_reg[`SDIL_CODE_W-2:0], serial_code_in};
        end
    end

    // Count saturates at a full code; overrun marks a dropped bit
    always @* begin
        cnt_next = cnt_reg;
        ovr_next = ovr_reg;
        if (frame_restart) begin
            cnt_next = `SDIL_CNT_RST;
            ovr_next = 1'b0;
        end
        if (shift_en) begin
            if (cnt_next == `SDIL_CNT_FULL) begin
                ovr_next = 1'b1;
            end else begin
                cnt_next = cnt_next + 4'h1;
            end
        end
    end

    // Shift data survives loads; only reset clears it
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_reg <= `SDIL_CODE_RST;
        end else begin
            shift_reg <= shift_next;
        end
    end

    // Overrun clears only on reset, a load fall or a select fall
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= `SDIL_CNT_RST;
            ovr_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            ovr_reg <= ovr_next;
        end
    end

    // ==========================================
    // DAC register
    reg [`SDIL_CODE_W-1:0] dac_reg;
    reg [`SDIL_CODE_W-1:0] dac_next;
    wire clear_active;
    wire load_active;

    // Clear has priority, so the latch is never open during a clear
    assign clear_active = ~clear_strobe_n;
    assign load_active = ~load_strobe_n & clear_strobe_n;

    // Transparent while load is low, so it tracks any shift then too
    always @* begin
        dac_next = dac_reg;
        if (clear_active) begin
            dac_next = `SDIL_CODE_ZERO;
        end else if (load_active) begin
            dac_next = shift_next;
        end
    end

    // Clear and load act on the system clock, one cycle late
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dac_reg <= `SDIL_CODE_RST;
        end else begin
            dac_reg <= dac_next;
        end
    end

    // ==========================================
    // Output level
    wire [`SDIL_UV_W-1:0] code_ext;
    wire [`SDIL_UV_W-1:0] uv_next;

    // Fits: largest code times step stays below two to the 21
    assign code_ext = {9'h000, dac_next};
    assign uv_next = code_ext * `SDIL_STEP_UV;

    // DAC code and level move together, in the same cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            analog_output <= `SDIL_CODE_RST;
            analog_output_uv <= `SDIL_UV_RST;
        end else begin
            analog_output <= dac_next;
            analog_output_uv <= uv_next;
        end
    end

    // ==========================================
    // Shift status
    wire complete_next;

    assign complete_next = (cnt_next == `SDIL_CNT_FULL);

    // Outputs take next values, so they agree with the registers
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_contents <= `SDIL_CODE_RST;
            bit_count <= `SDIL_CNT_RST;
            code_complete <= 1'b0;
            overrun <= 1'b0;
        end else begin
            shift_contents <= shift_next;
            bit_count <= cnt_next;
            code_complete <= complete_next;
            overrun <= ovr_next;
        end
    end

    // ==========================================
    // Code point flags
    wire transparent_next;
    wire full_next;
    wire mid_next;
    wire zero_next;

    // Open latch reported so a host can hold off the serial clock
    assign transparent_next = load_active;
    assign full_next = (dac_next == `SDIL_CODE_FULL_SCALE);
    assign mid_next = (dac_next == `SDIL_CODE_MID_SCALE);
    assign zero_next = (dac_next == `SDIL_CODE_ZERO);

    // Reset shows zero scale, matching the cleared DAC register
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dac_transparent <= 1'b0;
            at_full_scale <= 1'b0;
            at_mid_scale <= 1'b0;
            at_zero <= 1'b1;
        end else begin
            dac_transparent <= transparent_next;
            at_full_scale <= full_next;
            at_mid_scale <= mid_next;
            at_zero <= zero_next;
        end
    end
endmodule // sdil_top
